// File: logic/eeac_array.sv
`timescale 1ns/1ps
`include "eeac_defs.svh"

module eeac_array
    import eeac_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [8:0] rd_addr,
    output logic [7:0]      rd_data,
    input  wire eeac_prog_t prog
);

    typedef struct packed {
        eeac_mode_t mode;
        logic [8:0] addr;
        logic [7:0] data;
    } eeac_arr_st_t;

    logic [7:0]   mem [0:511];
    eeac_arr_st_t st_r;
    eeac_arr_st_t st_nxt;
    logic [7:0]   cell_nxt;

    // Latches the target at start; unaffected by reset so a write completes.
    always_comb begin
        st_nxt = st_r;
        if (prog.start) begin
            st_nxt.mode = prog.mode;
            st_nxt.addr = prog.addr;
            st_nxt.data = prog.data;
        end
        case (st_r.mode)
            eeac_pm_atomic: cell_nxt = st_r.data;
            eeac_pm_erase:  cell_nxt = `EEAC_ERASED;
            eeac_pm_write:  cell_nxt = mem[st_r.addr] & st_r.data;
            default:        cell_nxt = mem[st_r.addr];
        endcase
    end

    // Registers the latch and stores the cell when the timer completes.
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
        if (prog.commit) begin
            mem[st_r.addr] <= cell_nxt;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule

// File: logic/eeac_ctrl.sv
`timescale 1ns/1ps
`include "eeac_defs.svh"

module eeac_ctrl
    import eeac_pkg::*;
#(
    parameter int unsigned ATOM_OSC_CYCLES  = `EEAC_ATOM_OSC,
    parameter int unsigned SPLIT_OSC_CYCLES = `EEAC_SPLIT_OSC
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire eeac_io_t   io,
    input  wire logic       global_irq_en,
    input  wire logic       flash_selfprog_busy,
    input  wire logic       osc_tick,
    output logic [7:0]      ctrl_rdata,
    output logic [8:0]      addr_rdata,
    output logic [7:0]      data_rdata,
    output logic            cpu_stall,
    output logic            ready_irq
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------

    typedef struct packed {
        eeac_mode_t prog_mode_field;
        logic       ready_irq_enable;
        logic       master_write_enable;
        logic [1:0] mwe_cnt;
        logic       write_strobe;
        logic       start;
        logic [2:0] stall_cnt;
        logic       stall;
        logic       irq;
        logic [8:0] nv_byte_address;
        logic [7:0] nv_byte_data;
    } eeac_ctrl_st_t;

    eeac_ctrl_st_t st_r;
    eeac_ctrl_st_t st_nxt;

    logic        wr_go;
    logic        rd_go;
    logic        t_busy;
    logic        t_done;
    logic [14:0] t_load;
    logic [7:0]  arr_rdata;
    eeac_prog_t  prog;

    // ------------------------------------------------------------------
    // Strobe qualification.
    // ------------------------------------------------------------------

    // A write strobe starts programming only inside the enable window.
    assign wr_go = io.wr_ctrl && io.wdata[`EEAC_BIT_WSTB]
                && st_r.master_write_enable
                && !st_r.write_strobe
                && !flash_selfprog_busy
                && (st_r.prog_mode_field != eeac_pm_rsvd);

    // A read strobe is refused while a write is being programmed.
    assign rd_go = io.wr_ctrl && io.wdata[`EEAC_BIT_RSTB]
                && !st_r.write_strobe
                && !wr_go;

    // Programming time in oscillator cycles for the locked mode.
    assign t_load = (st_r.prog_mode_field == eeac_pm_atomic)
                  ? 15'(ATOM_OSC_CYCLES)
                  : 15'(SPLIT_OSC_CYCLES);

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------

    // Computes every register update for the coming edge.
    always_comb begin
        st_nxt = st_r;
        st_nxt.start = 1'b0;

        // Master enable times out four cycles after being set.
        if (st_r.master_write_enable) begin
            if (st_r.mwe_cnt == 2'h0) begin
                st_nxt.master_write_enable = 1'b0;
            end else begin
                st_nxt.mwe_cnt = st_r.mwe_cnt - 2'h1;
            end
        end

        // Stall counter runs down once per cycle.
        if (st_r.stall_cnt != 3'h0) begin
            st_nxt.stall_cnt = st_r.stall_cnt - 3'h1;
        end

        // Completion of the programming time frees the strobe.
        if (t_done) begin
            st_nxt.write_strobe = 1'b0;
        end

        // Address may only change while no write is in progress.
        if (io.wr_addr_lo && !st_r.write_strobe) begin
            st_nxt.nv_byte_address[7:0] = io.wdata;
        end
        if (io.wr_addr_hi && !st_r.write_strobe) begin
            st_nxt.nv_byte_address[8] = io.wdata[0];
        end

        // Data byte written by software.
        if (io.wr_data) begin
            st_nxt.nv_byte_data = io.wdata;
        end

        // Control register write.
        if (io.wr_ctrl) begin
            st_nxt.ready_irq_enable = io.wdata[`EEAC_BIT_RIE];
            if (!st_r.write_strobe) begin
                st_nxt.prog_mode_field = eeac_mode_t'(
                    io.wdata[`EEAC_BIT_PM_HI:`EEAC_BIT_PM_LO]);
            end
            if (io.wdata[`EEAC_BIT_MWE]) begin
                st_nxt.master_write_enable = 1'b1;
                st_nxt.mwe_cnt = 2'(`EEAC_MWE_CYCLES - 1);
            end else begin
                st_nxt.master_write_enable = 1'b0;
            end
            if (wr_go) begin
                st_nxt.write_strobe = 1'b1;
                st_nxt.start        = 1'b1;
                st_nxt.stall_cnt    = 3'(`EEAC_WR_STALL);
            end
            if (rd_go) begin
                st_nxt.nv_byte_data = arr_rdata;
                st_nxt.stall_cnt    = 3'(`EEAC_RD_STALL);
            end
        end

        st_nxt.stall = (st_nxt.stall_cnt != 3'h0);

        // Ready interrupt is a level while idle and enabled.
        st_nxt.irq = st_r.ready_irq_enable && global_irq_en
                  && !st_r.write_strobe && !flash_selfprog_busy;

        // Reset clears control but spares a write in progress.
        if (!rst_n) begin
            st_nxt = '0;
            st_nxt.ready_irq_enable = 1'(`EEAC_CTRL_RST >> `EEAC_BIT_RIE);
            st_nxt.nv_byte_address  = `EEAC_ADDR_RST;
            st_nxt.nv_byte_data     = `EEAC_DATA_RST;
            st_nxt.prog_mode_field  = eeac_pm_atomic;
            if (st_r.write_strobe) begin
                st_nxt.write_strobe    = !t_done;
                st_nxt.prog_mode_field = st_r.prog_mode_field;
                st_nxt.nv_byte_address = st_r.nv_byte_address;
            end
        end
    end

    // Registers the whole state.
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Programming timer and byte array.
    // ------------------------------------------------------------------

    // Times the selected operation from the oscillator tick.
    eeac_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (st_r.start),
        .load     (t_load),
        .osc_tick (osc_tick),
        .busy     (t_busy),
        .done     (t_done)
    );

    // Programming request built from registered state.
    assign prog.start  = st_r.start;
    assign prog.commit = t_done;
    assign prog.mode   = st_r.prog_mode_field;
    assign prog.addr   = st_r.nv_byte_address;
    assign prog.data   = st_r.nv_byte_data;

    // Holds the 512 data bytes.
    eeac_array u_array (
        .clk     (clk),
        .rd_addr (st_r.nv_byte_address),
        .rd_data (arr_rdata),
        .prog    (prog)
    );

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------

    // Control readback with the reserved bits held at zero.
    assign ctrl_rdata = {2'b00,
                         st_r.prog_mode_field,
                         st_r.ready_irq_enable,
                         st_r.master_write_enable,
                         st_r.write_strobe,
                         1'b0};
    assign addr_rdata = st_r.nv_byte_address;
    assign data_rdata = st_r.nv_byte_data;
    assign cpu_stall  = st_r.stall;
    assign ready_irq  = st_r.irq;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic strobe_try;
    assign strobe_try = io.wr_ctrl && io.wdata[`EEAC_BIT_WSTB];

    // Reserved bits read as zero.
    property p_rsvd_zero;
        ctrl_rdata[7:6] == 2'b00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

    // Mode field stays put while programming.
    property p_mode_locked;
        (st_r.write_strobe && io.wr_ctrl) |=> $stable(ctrl_rdata[5:4]);
    endproperty
    a_mode_locked: assert property (p_mode_locked) else $error("mode changed while busy");

    // Master enable drops four cycles after rising when left alone.
    property p_mwe_timeout;
        ($rose(ctrl_rdata[2]) ##0 (!io.wr_ctrl)[*4]) |=> !ctrl_rdata[2];
    endproperty
    a_mwe_timeout: assert property (p_mwe_timeout) else $error("enable did not time out");

    // Master enable holds through its whole window.
    property p_mwe_window;
        ($rose(ctrl_rdata[2]) ##0 (!io.wr_ctrl)[*4])
            |-> ctrl_rdata[2] && $past(ctrl_rdata[2]) && $past(ctrl_rdata[2], 2);
    endproperty
    a_mwe_window: assert property (p_mwe_window) else $error("enable window short");

    // A strobe without master enable has no effect.
    property p_no_mwe;
        (strobe_try && !ctrl_rdata[2] && !ctrl_rdata[1]) |=> !ctrl_rdata[1];
    endproperty
    a_no_mwe: assert property (p_no_mwe) else $error("write started without enable");

    // A qualified strobe sets the strobe bit one cycle later and the timer runs the cycle after.
    property p_start;
        (strobe_try && ctrl_rdata[2] && !ctrl_rdata[1] && !flash_selfprog_busy
            && ctrl_rdata[5:4] != 2'b11) |=> ctrl_rdata[1] ##1 t_busy;
    endproperty
    a_start: assert property (p_start) else $error("write not started");

    // Flash self-programming blocks a new write.
    property p_flash_lock;
        (strobe_try && flash_selfprog_busy && !ctrl_rdata[1]) |=> !ctrl_rdata[1];
    endproperty
    a_flash_lock: assert property (p_flash_lock) else $error("write during flash");

    // Timer completion clears the strobe.
    property p_done_clears;
        t_done |=> !ctrl_rdata[1];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("strobe not cleared");

    // Accepted write stalls exactly two cycles.
    property p_wr_stall;
        wr_go |=> cpu_stall [*2] ##1 !cpu_stall;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall wrong");

    // Accepted read stalls exactly four cycles and loads the byte.
    property p_rd_stall;
        rd_go |=> (data_rdata == $past(arr_rdata)) ##0 cpu_stall [*4] ##1 !cpu_stall;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall wrong");

    // Address cannot change while programming.
    property p_addr_hold;
        ctrl_rdata[1] |=> $stable(addr_rdata);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved while busy");

    // Interrupt is low after any busy cycle and high when idle and enabled.
    property p_irq;
        (ctrl_rdata[1] || flash_selfprog_busy) |=> !ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt while busy");

    property p_irq_on;
        (ctrl_rdata[3] && global_irq_en && !ctrl_rdata[1] && !flash_selfprog_busy)
            |=> ready_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("ready interrupt missing");

    // An idle reset returns the mode field to atomic.
    property p_reset_mode;
        disable iff (1'b0) (!rst_n && !ctrl_rdata[1]) |=> ctrl_rdata[5:4] == 2'b00;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode kept by idle reset");

    // A reset during programming keeps strobe, mode and address.
    property p_reset_keep;
        disable iff (1'b0) (!rst_n && ctrl_rdata[1] && !t_done)
            |=> ctrl_rdata[1] && $stable(ctrl_rdata[5:4]) && $stable(addr_rdata);
    endproperty
    a_reset_keep: assert property (p_reset_keep) else $error("write lost at reset");

    // A software data write lands unless a read overrides it.
    property p_data_wr;
        (io.wr_data && !rd_go) |=> data_rdata == $past(io.wdata);
    endproperty
    a_data_wr: assert property (p_data_wr) else $error("data write lost");

    // An idle low address write lands in the address register.
    property p_addr_wr;
        (io.wr_addr_lo && !ctrl_rdata[1]) |=> addr_rdata[7:0] == $past(io.wdata);
    endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("address write lost");

endmodule

// File: logic/eeac_defs.svh
`ifndef EEAC_DEFS_SVH
`define EEAC_DEFS_SVH

// ----------------------------------------------------------------------
// Access control register bit positions.
// ----------------------------------------------------------------------
`define EEAC_BIT_RSTB     0
`define EEAC_BIT_WSTB     1
`define EEAC_BIT_MWE      2
`define EEAC_BIT_RIE      3
`define EEAC_BIT_PM_LO    4
`define EEAC_BIT_PM_HI    5

// ----------------------------------------------------------------------
// Reset values and the erased byte value.
// ----------------------------------------------------------------------
`define EEAC_CTRL_RST     8'h00
`define EEAC_ADDR_RST     9'h000
`define EEAC_DATA_RST     8'h00
`define EEAC_ERASED       8'hFF

// ----------------------------------------------------------------------
// Timing: programming times in microseconds and oscillator cycles.
// ----------------------------------------------------------------------
`define EEAC_T_ATOM_US    3400
`define EEAC_T_SPLIT_US   1800
`define EEAC_ATOM_OSC     26368
`define EEAC_SPLIT_OSC    (`EEAC_ATOM_OSC * `EEAC_T_SPLIT_US / `EEAC_T_ATOM_US)
`define EEAC_MWE_CYCLES   4
`define EEAC_WR_STALL     2
`define EEAC_RD_STALL     4

`endif

// File: logic/eeac_pkg.sv
package eeac_pkg;

    // Programming mode field encodings.
    typedef enum logic [1:0] {
        eeac_pm_atomic,
        eeac_pm_erase,
        eeac_pm_write,
        eeac_pm_rsvd
    } eeac_mode_t;

    // Programming timer states.
    typedef enum logic {
        eeac_t_idle,
        eeac_t_run
    } eeac_tstate_t;

    // CPU I/O register write strobes with their data byte.
    typedef struct packed {
        logic       wr_ctrl;
        logic       wr_addr_lo;
        logic       wr_addr_hi;
        logic       wr_data;
        logic [7:0] wdata;
    } eeac_io_t;

    // Programming request towards the byte array.
    typedef struct packed {
        logic       start;
        logic       commit;
        eeac_mode_t mode;
        logic [8:0] addr;
        logic [7:0] data;
    } eeac_prog_t;

endpackage

// File: logic/eeac_timer.sv
`timescale 1ns/1ps
`include "eeac_defs.svh"

module eeac_timer
    import eeac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [14:0] load,
    input  wire logic        osc_tick,
    output logic             busy,
    output logic             done
);

    typedef struct packed {
        eeac_tstate_t state;
        logic [14:0]  cnt;
        logic         done;
    } eeac_tmr_st_t;

    eeac_tmr_st_t st_r;
    eeac_tmr_st_t st_nxt;

    // Counts oscillator ticks; a running count ignores reset so it completes.
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        case (st_r.state)
            eeac_t_idle: begin
                if (start) begin
                    st_nxt.state = eeac_t_run;
                    st_nxt.cnt   = load;
                end else if (!rst_n) begin
                    st_nxt.cnt = 15'h0000;
                end
            end
            eeac_t_run: begin
                if (osc_tick && st_r.cnt <= 15'h0001) begin
                    st_nxt.state = eeac_t_idle;
                    st_nxt.cnt   = 15'h0000;
                    st_nxt.done  = 1'b1;
                end else if (osc_tick) begin
                    st_nxt.cnt = st_r.cnt - 15'h0001;
                end
            end
            default: st_nxt = '0;
        endcase
    end

    // Registers the timer state.
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign busy = (st_r.state == eeac_t_run);
    assign done = st_r.done;

endmodule

// File: verif/eeac_cpu_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// CPU side: register strobes, interrupt flag, flash busy, oscillator.
// ----------------------------------------------------------------------
module eeac_cpu_model
    import eeac_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] ctrl_rdata,
    output eeac_io_t        io,
    output logic            global_irq_en,
    output logic            flash_selfprog_busy,
    output logic            osc_tick
);
    logic tick_r = 1'b0;

    initial begin
        io = '0;
        global_irq_en = 1'b0;
        flash_selfprog_busy = 1'b0;
    end

    // The oscillator ticks on every second clock, slower than the core.
    always @(posedge clk) begin
        tick_r <= ~tick_r;
    end
    assign osc_tick = tick_r;

    // One register write; k is {ctrl, addr_lo, addr_hi, data}, taken at the second edge.
    task automatic wr(input logic [3:0] k, input logic [7:0] d);
        @(posedge clk);
        io <= {k, d};
        @(posedge clk);
        io <= '0;
    endtask

    // Sets the global interrupt flag and the flash busy line at the next edge.
    task automatic set_lines(input logic g, input logic f);
        @(posedge clk);
        global_irq_en <= g;
        flash_selfprog_busy <= f;
    endtask

    // Full write sequence; returns at the edge that takes the write strobe.
    task automatic prog_byte(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        // A write that never completes is caught by the watchdog.
        while (ctrl_rdata[1] !== 1'b0 || flash_selfprog_busy !== 1'b0) begin
            @(posedge clk);
        end
        global_irq_en <= 1'b0;
        wr(4'h4, a[7:0]);
        wr(4'h2, {7'h00, a[8]});
        wr(4'h1, d);
        wr(4'h8, {2'b00, m, 4'h4});
        wr(4'h8, {2'b00, m, 4'h2});
    endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps

module tb;
    import eeac_pkg::*;

    localparam int unsigned NA = 20;
    localparam int unsigned NS = 10;

    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    eeac_io_t   io;
    logic       g_en;
    logic       f_busy;
    logic       tick;
    logic [7:0] ctrl;
    logic [8:0] addr;
    logic [7:0] data;
    logic       stall;
    logic       irq;
    int         num_errors = 0;
    int         check_count = 0;

    // Clock of 50 ns period.
    always #25 clk = ~clk;

    eeac_ctrl #(.ATOM_OSC_CYCLES(NA), .SPLIT_OSC_CYCLES(NS)) uut (
        .clk(clk), .rst_n(rst_n), .io(io), .global_irq_en(g_en),
        .flash_selfprog_busy(f_busy), .osc_tick(tick), .ctrl_rdata(ctrl),
        .addr_rdata(addr), .data_rdata(data), .cpu_stall(stall), .ready_irq(irq)
    );

    eeac_cpu_model cpu (
        .clk(clk), .ctrl_rdata(ctrl), .io(io),
        .global_irq_en(g_en), .flash_selfprog_busy(f_busy), .osc_tick(tick)
    );

    // ------------------------------------------------------------------
    // Shared checking and timing tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test;
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic nxt;
        @(posedge clk);
        #1;
    endtask

    // Caller sits just after the edge that took the strobe.
    task automatic chk_stall(input int n);
        for (int i = 0; i < n; i++) begin
            chk({8'h00, stall}, 9'h001, "stall held");
            nxt();
        end
        chk({8'h00, stall}, 9'h000, "stall released");
    endtask

    // Waits for the write strobe to clear; n above zero also checks the duration.
    task automatic wait_done(input int n);
        int c;
        c = 0;
        while (ctrl[1] === 1'b1 && c < 400) begin
            nxt();
            c++;
        end
        chk({8'h00, ctrl[1]}, 9'h000, "strobe cleared");
        if (n > 0) begin
            chk({8'h00, c >= 2 * n - 3 && c <= 2 * n + 8}, 9'h001, "program time");
        end
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        cpu.wr(4'h4, a[7:0]);
        cpu.wr(4'h2, {7'h00, a[8]});
        cpu.wr(4'h8, 8'h01);
        #1;
        chk({1'b0, data}, {1'b0, exp}, "read byte");
        chk_stall(4);
    endtask

    // Programs one byte in mode m and reads it back.
    task automatic do_prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d,
                           input int n, input logic [7:0] exp);
        cpu.prog_byte(m, a, d);
        #1;
        chk({7'h00, ctrl[5:4]}, {7'h00, m}, "mode held");
        chk({8'h00, ctrl[1]}, 9'h001, "strobe set");
        chk_stall(2);
        wait_done(n);
        rd(a, exp);
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_mwe;
        cpu.wr(4'h8, 8'h04);
        #1;
        for (int i = 0; i < 4; i++) begin
            chk({8'h00, ctrl[2]}, 9'h001, "enable held");
            if (i < 3) begin
                nxt();
            end
        end
        nxt();
        chk({8'h00, ctrl[2]}, 9'h000, "enable expired");
        cpu.wr(4'h8, 8'h02);
        #1;
        chk({8'h00, ctrl[1]}, 9'h000, "late strobe refused");
        chk({8'h00, stall}, 9'h000, "no stall on refusal");
    endtask

    task automatic t_modes;
        do_prog(2'b00, 9'h1A5, 8'h5A, NA, 8'h5A);
        do_prog(2'b01, 9'h1A5, 8'h00, NS, 8'hFF);
        do_prog(2'b10, 9'h1A5, 8'h3C, NS, 8'h3C);
        cpu.prog_byte(2'b11, 9'h1A5, 8'h00);
        #1;
        chk({8'h00, ctrl[1]}, 9'h000, "reserved mode refused");
        rd(9'h1A5, 8'h3C);
    endtask

    task automatic t_busy;
        cpu.prog_byte(2'b00, 9'h0F0, 8'h81);
        cpu.wr(4'h8, 8'h20);
        cpu.wr(4'h4, 8'h11);
        cpu.wr(4'h8, 8'h01);
        #1;
        chk({7'h00, ctrl[5:4]}, 9'h000, "mode locked");
        chk(addr, 9'h0F0, "address locked");
        chk({1'b0, data}, 9'h081, "read blocked");
        chk({8'h00, stall}, 9'h000, "no stall on blocked read");
        wait_done(0);
        rd(9'h0F0, 8'h81);
    endtask

    task automatic t_irq;
        cpu.set_lines(1'b1, 1'b0);
        cpu.wr(4'h8, 8'hC8);
        #1;
        chk({1'b0, ctrl}, 9'h008, "reserved bits");
        nxt();
        chk({8'h00, irq}, 9'h001, "ready irq");
        cpu.set_lines(1'b1, 1'b1);
        nxt();
        chk({8'h00, irq}, 9'h000, "irq during flash");
        cpu.set_lines(1'b0, 1'b0);
        nxt();
        chk({8'h00, irq}, 9'h000, "irq global off");
        cpu.wr(4'h8, 8'h0C);
        cpu.wr(4'h8, 8'h0A);
        cpu.set_lines(1'b1, 1'b0);
        nxt();
        nxt();
        chk({8'h00, irq}, 9'h000, "irq during write");
        wait_done(0);
        nxt();
        chk({8'h00, irq}, 9'h001, "irq after write");
        cpu.set_lines(1'b0, 1'b1);
        cpu.wr(4'h8, 8'h04);
        cpu.wr(4'h8, 8'h02);
        #1;
        chk({8'h00, ctrl[1]}, 9'h000, "flash busy refusal");
        cpu.set_lines(1'b0, 1'b0);
    endtask

    task automatic t_reset;
        cpu.wr(4'h8, 8'h20);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({1'b0, ctrl}, 9'h000, "idle reset clears mode");
        cpu.prog_byte(2'b01, 9'h033, 8'h00);
        nxt();
        nxt();
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({1'b0, ctrl}, 9'h012, "busy reset keeps mode");
        wait_done(0);
        rd(9'h033, 8'hFF);
    endtask

    // Main sequence: reset for five cycles, then the scenarios.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({1'b0, ctrl}, 9'h000, "reset control");
        chk({7'h00, stall, irq}, 9'h000, "reset outputs");
        t_mwe();
        t_modes();
        t_busy();
        t_irq();
        t_reset();
        stop_test();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule
